// File: hw/irq_route_pkg.sv
// constants for the interrupt routing, prioritising and vector unit
// assumes a single core clock; registers reached through the coprocessor port
package irq_route_pkg;
  localparam int NUM_SRC = 64;
  localparam int NUM_EXT = 8;
  // coprocessor register numbers (crn field), 16 registers
  localparam logic [3:0] CRN_ENABLE0 = 4'h0;
  localparam logic [3:0] CRN_ENABLE1 = 4'h1;
  localparam logic [3:0] CRN_STEER0 = 4'h2;
  localparam logic [3:0] CRN_STEER1 = 4'h3;
  localparam logic [3:0] CRN_IRQ_PEND0 = 4'h4;
  localparam logic [3:0] CRN_IRQ_PEND1 = 4'h5;
  localparam logic [3:0] CRN_FIQ_PEND0 = 4'h6;
  localparam logic [3:0] CRN_FIQ_PEND1 = 4'h7;
  localparam logic [3:0] CRN_PRIO0 = 4'h8;
  localparam logic [3:0] CRN_PRIO1 = 4'hA;
  localparam logic [3:0] CRN_PRIO3 = 4'hB;
  localparam logic [3:0] CRN_BASE = 4'hC;
  localparam logic [3:0] CRN_SPAN = 4'hD;
  localparam logic [3:0] CRN_IRQ_VEC = 4'hE;
  localparam logic [3:0] CRN_FIQ_VEC = 4'hF;
  localparam logic [3:0] CRN_ROUTE = 4'h9;
  // route select fields
  localparam int ROUTE_CORE_LSB = 0;
  localparam int ROUTE_SEG_LSB = 16;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  localparam logic [31:0] ROUTE_MASK = 32'h00FF_00FF;
  // source map
  localparam int SRC_EXT_LSB = 0;
  localparam int SRC_GPIO_LSB = 8;
  localparam int SRC_URGENT = 16;
  localparam int SRC_TIMER0 = 17;
  localparam int SRC_TIMER1 = 18;
  localparam int SRC_WDOG = 19;
  localparam int SRC_PERIPH_LSB = 20;
  localparam int NUM_PERIPH = 44;
  localparam int MU_FWD_INPUT = 14;
  localparam logic [63:0] ENABLE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STEER_RESET = 64'h0000_0000_0000_0000;
  localparam logic [127:0] PRIO_RESET = 128'h0;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [3:0] SPAN_RESET = 4'h0;
  localparam int SPAN_MIN_SHIFT = 8;
  // span code where 2^(n+1) sizing starts; this code and all lower codes give 256 bytes
  localparam logic [3:0] SPAN_MIN_CODE = 4'h7;
endpackage

// File: hw/prio_pick.sv
// picks the highest-priority pending source of one path and forms its vector
// assumes base and span are stable register values; pending set and priority fields come from combinational next values
`timescale 1ns/10ps
`default_nettype none
module prio_pick (
  input wire logic [63:0] pend_i,
  input wire logic [127:0] prio_i,
  input wire logic [31:0] base_i,
  input wire logic [3:0] span_i,
  output logic valid_o,
  output logic [31:0] vector_o
);
  logic [5:0] best_idx;
  logic [1:0] best_pri;
  logic found;
  logic [4:0] shift;

  always_comb
  begin
    best_idx = 6'h0;
    best_pri = 2'h3;
    found = 1'b0;
    // ascending scan with <= lets the higher bit win a tie
    for (int i = 0; i < irq_route_pkg::NUM_SRC; i++)
    begin
      if (pend_i[i] && (!found || prio_i[2*i +: 2] <= best_pri))
      begin
        found = 1'b1;
        best_pri = prio_i[2*i +: 2];
        best_idx = 6'(i);
      end
    end
  end

  // span code n from 7 up gives 2^(n+1) bytes per source, so 4'hf tops out at 64 kbyte
  always_comb
  begin
    if (span_i < irq_route_pkg::SPAN_MIN_CODE)
      shift = 5'(irq_route_pkg::SPAN_MIN_SHIFT);
    else
      shift = 5'(span_i) + 5'h01;
  end

  assign valid_o = found;
  assign vector_o = base_i + (32'(best_idx) << shift);
endmodule
`default_nettype wire

// File: hw/irq_route_prio_vector_unit.sv
// interrupt routing, masking, steering, prioritising and vector unit
// assumes request levels already synchronous; coprocessor access takes one cycle
//
// Behaviour
// - route bits 0-7 pick core or forwarder
// - route bits 16-23 pick segment B or A
// - unrouted core input sits inactive high
// - requests are levels, never edges
// - seventeen external request pins accepted
// - timers and watchdog are request sources
// - every source merges into IRQ or FIQ
// - disabled source never pends nor interrupts
// - steering picks FIQ or IRQ per source
// - pending registers read-only, show active unmasked
// - two-bit priority, 00 highest 11 lowest
// - one winner chosen per path
// - equal priority, highest bit wins
// - span from 256 bytes to 64 kbytes
// - vector is base plus span times index
// - vector registers show path winner vector
// - sixteen registers selected by crn field
// - write effective before next instruction
// - pins synchronised, requests only when unmasked
// - urgent pin never reaches forwarders
`timescale 1ns/10ps
`default_nettype none
module irq_route_prio_vector_unit #(
  parameter int NUM_PERIPH = 44
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] ext_request_pins_n_i,
  input wire logic [7:0] gpio_request_pins_n_i,
  input wire logic [7:0] gpio_is_input_i,
  input wire logic urgent_request_pin_n_i,
  input wire logic timer0_req_i,
  input wire logic timer1_req_i,
  input wire logic wdog_req_i,
  input wire logic [NUM_PERIPH-1:0] periph_req_i,
  input wire logic message_unit_req_i,
  input wire logic cp_wr_i,
  input wire logic cp_rd_i,
  input wire logic [3:0] cp_crn_i,
  input wire logic [2:0] cp_opcode1_i,
  input wire logic [2:0] cp_opcode2_i,
  input wire logic [3:0] cp_crm_i,
  input wire logic [31:0] cp_wdata_i,
  output logic [31:0] cp_rdata_o,
  output logic [7:0] fwd_a_req_n_o,
  output logic [7:0] fwd_b_req_n_o,
  output logic fwd_a_mu_req_n_o,
  output logic irq_o,
  output logic fiq_o,
  output logic [31:0] irq_vector_out_o,
  output logic [31:0] fiq_vector_out_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] external_pin_route_select_ff;
  logic [63:0] source_enable_ctl_ff;
  logic [63:0] path_steer_select_ff;
  logic [127:0] source_priority_fields_ff;
  logic [31:0] handler_base_ff;
  logic [3:0] handler_span_ff;
  logic [7:0] ext_sync1_ff;
  logic [7:0] ext_sync2_ff;
  logic [7:0] gpio_sync1_ff;
  logic [7:0] gpio_sync2_ff;
  logic urgent_sync1_ff;
  logic urgent_sync2_ff;
  logic [7:0] core_ext_n;
  logic [63:0] raw_level;
  logic [63:0] irq_pending_set;
  logic [63:0] fiq_pending_set;
  logic [63:0] nxt_enable;
  logic [63:0] nxt_steer;
  logic [127:0] nxt_prio;
  logic irq_valid;
  logic fiq_valid;
  logic [31:0] irq_vec;
  logic [31:0] fiq_vec;
  logic cp_ok;
  logic [31:0] nxt_rdata;

  // accesses with nonzero opcode or crm fields are ignored
  assign cp_ok = (cp_opcode1_i == 3'h0) && (cp_opcode2_i == 3'h0) && (cp_crm_i == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_sync1_ff <= 8'hFF;
      ext_sync2_ff <= 8'hFF;
      gpio_sync1_ff <= 8'hFF;
      gpio_sync2_ff <= 8'hFF;
      urgent_sync1_ff <= 1'b1;
      urgent_sync2_ff <= 1'b1;
    end
    else
    begin
      ext_sync1_ff <= ext_request_pins_n_i;
      ext_sync2_ff <= ext_sync1_ff;
      gpio_sync1_ff <= gpio_request_pins_n_i;
      gpio_sync2_ff <= gpio_sync1_ff;
      urgent_sync1_ff <= urgent_request_pin_n_i;
      urgent_sync2_ff <= urgent_sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing: core select, then segment select; unrouted inputs held high
  always_comb
  begin
    for (int n = 0; n < irq_route_pkg::NUM_EXT; n++)
    begin
      if (external_pin_route_select_ff[irq_route_pkg::ROUTE_CORE_LSB + n])
        core_ext_n[n] = ext_sync2_ff[n];
      else
        core_ext_n[n] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fwd_a_req_n_o <= 8'hFF;
      fwd_b_req_n_o <= 8'hFF;
      fwd_a_mu_req_n_o <= 1'b1;
    end
    else
    begin
      for (int n = 0; n < irq_route_pkg::NUM_EXT; n++)
      begin
        // urgent pin has no path here at all
        if (!external_pin_route_select_ff[irq_route_pkg::ROUTE_CORE_LSB + n])
        begin
          fwd_b_req_n_o[n] <= external_pin_route_select_ff[irq_route_pkg::ROUTE_SEG_LSB + n]
            ? ext_sync2_ff[n] : 1'b1;
          fwd_a_req_n_o[n] <= external_pin_route_select_ff[irq_route_pkg::ROUTE_SEG_LSB + n]
            ? 1'b1 : ext_sync2_ff[n];
        end
        else
        begin
          fwd_a_req_n_o[n] <= 1'b1;
          fwd_b_req_n_o[n] <= 1'b1;
        end
      end
      fwd_a_mu_req_n_o <= !message_unit_req_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source vector; all inputs taken as present levels
  always_comb
  begin
    raw_level = 64'h0;
    raw_level[irq_route_pkg::SRC_EXT_LSB +: 8] = ~core_ext_n;
    raw_level[irq_route_pkg::SRC_GPIO_LSB +: 8] = ~gpio_sync2_ff & gpio_is_input_i;
    raw_level[irq_route_pkg::SRC_URGENT] = !urgent_sync2_ff;
    raw_level[irq_route_pkg::SRC_TIMER0] = timer0_req_i;
    raw_level[irq_route_pkg::SRC_TIMER1] = timer1_req_i;
    raw_level[irq_route_pkg::SRC_WDOG] = wdog_req_i;
    raw_level[irq_route_pkg::SRC_PERIPH_LSB +: NUM_PERIPH] = periph_req_i;
  end

  // the next register values feed pending directly so a write counts at once
  assign irq_pending_set = raw_level & nxt_enable & ~nxt_steer;
  assign fiq_pending_set = raw_level & nxt_enable & nxt_steer;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb
  begin
    nxt_enable = source_enable_ctl_ff;
    nxt_steer = path_steer_select_ff;
    nxt_prio = source_priority_fields_ff;
    if (cp_wr_i && cp_ok)
    begin
      unique case (cp_crn_i)
        irq_route_pkg::CRN_ENABLE0: nxt_enable[31:0] = cp_wdata_i;
        irq_route_pkg::CRN_ENABLE1: nxt_enable[63:32] = cp_wdata_i;
        irq_route_pkg::CRN_STEER0: nxt_steer[31:0] = cp_wdata_i;
        irq_route_pkg::CRN_STEER1: nxt_steer[63:32] = cp_wdata_i;
        irq_route_pkg::CRN_PRIO0: nxt_prio[31:0] = cp_wdata_i;
        irq_route_pkg::CRN_PRIO1: nxt_prio[63:32] = cp_wdata_i;
        irq_route_pkg::CRN_PRIO3: nxt_prio[127:96] = cp_wdata_i;
        irq_route_pkg::CRN_ROUTE: nxt_prio[127:96] = nxt_prio[127:96];
        default: nxt_prio = nxt_prio;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      source_enable_ctl_ff <= irq_route_pkg::ENABLE_RESET;
      path_steer_select_ff <= irq_route_pkg::STEER_RESET;
      source_priority_fields_ff <= irq_route_pkg::PRIO_RESET;
    end
    else
    begin
      source_enable_ctl_ff <= nxt_enable;
      path_steer_select_ff <= nxt_steer;
      source_priority_fields_ff <= nxt_prio;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      handler_base_ff <= irq_route_pkg::BASE_RESET;
      handler_span_ff <= irq_route_pkg::SPAN_RESET;
      external_pin_route_select_ff <= irq_route_pkg::ROUTE_RESET;
    end
    else if (cp_wr_i && cp_ok)
    begin
      if (cp_crn_i == irq_route_pkg::CRN_BASE)
        handler_base_ff <= cp_wdata_i;
      if (cp_crn_i == irq_route_pkg::CRN_SPAN)
        handler_span_ff <= cp_wdata_i[3:0];
      if (cp_crn_i == irq_route_pkg::CRN_ROUTE)
        external_pin_route_select_ff <= cp_wdata_i & irq_route_pkg::ROUTE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one prioritiser per path
  prio_pick u_irq_pick (
    .pend_i(irq_pending_set),
    .prio_i(nxt_prio),
    .base_i(handler_base_ff),
    .span_i(handler_span_ff),
    .valid_o(irq_valid),
    .vector_o(irq_vec)
  );

  prio_pick u_fiq_pick (
    .pend_i(fiq_pending_set),
    .prio_i(nxt_prio),
    .base_i(handler_base_ff),
    .span_i(handler_span_ff),
    .valid_o(fiq_valid),
    .vector_o(fiq_vec)
  );

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      fiq_o <= 1'b0;
      irq_vector_out_o <= 32'h0000_0000;
      fiq_vector_out_o <= 32'h0000_0000;
    end
    else
    begin
      irq_o <= |irq_pending_set;
      fiq_o <= |fiq_pending_set;
      irq_vector_out_o <= irq_valid ? irq_vec : handler_base_ff;
      fiq_vector_out_o <= fiq_valid ? fiq_vec : handler_base_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reads; pending and vector registers ignore writes
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (cp_crn_i)
      irq_route_pkg::CRN_ENABLE0: nxt_rdata = source_enable_ctl_ff[31:0];
      irq_route_pkg::CRN_ENABLE1: nxt_rdata = source_enable_ctl_ff[63:32];
      irq_route_pkg::CRN_STEER0: nxt_rdata = path_steer_select_ff[31:0];
      irq_route_pkg::CRN_STEER1: nxt_rdata = path_steer_select_ff[63:32];
      irq_route_pkg::CRN_IRQ_PEND0: nxt_rdata = irq_pending_set[31:0];
      irq_route_pkg::CRN_IRQ_PEND1: nxt_rdata = irq_pending_set[63:32];
      irq_route_pkg::CRN_FIQ_PEND0: nxt_rdata = fiq_pending_set[31:0];
      irq_route_pkg::CRN_FIQ_PEND1: nxt_rdata = fiq_pending_set[63:32];
      irq_route_pkg::CRN_PRIO0: nxt_rdata = source_priority_fields_ff[31:0];
      irq_route_pkg::CRN_ROUTE: nxt_rdata = external_pin_route_select_ff;
      irq_route_pkg::CRN_PRIO1: nxt_rdata = source_priority_fields_ff[63:32];
      irq_route_pkg::CRN_PRIO3: nxt_rdata = source_priority_fields_ff[127:96];
      irq_route_pkg::CRN_BASE: nxt_rdata = handler_base_ff;
      irq_route_pkg::CRN_SPAN: nxt_rdata = {28'h000_0000, handler_span_ff};
      irq_route_pkg::CRN_IRQ_VEC: nxt_rdata = irq_valid ? irq_vec : handler_base_ff;
      irq_route_pkg::CRN_FIQ_VEC: nxt_rdata = fiq_valid ? fiq_vec : handler_base_ff;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      cp_rdata_o <= 32'h0000_0000;
    else if (cp_rd_i && cp_ok)
      cp_rdata_o <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_core_unrouted_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    !external_pin_route_select_ff[0] |-> !raw_level[0];
  endproperty
  a_core_unrouted_quiet: assert property (p_core_unrouted_quiet) else $error("unrouted pin reached core");

  property p_fwd_exclusive;
    @(posedge mclk_i) disable iff (rst_i)
    external_pin_route_select_ff[0] |=> fwd_a_req_n_o[0] && fwd_b_req_n_o[0];
  endproperty
  a_fwd_exclusive: assert property (p_fwd_exclusive) else $error("core-routed pin reached forwarder");

  property p_seg_b;
    @(posedge mclk_i) disable iff (rst_i)
    (!external_pin_route_select_ff[1] && external_pin_route_select_ff[17]) |=> fwd_a_req_n_o[1];
  endproperty
  a_seg_b: assert property (p_seg_b) else $error("segment B pin reached segment A");

  property p_mu;
    @(posedge mclk_i) disable iff (rst_i)
    message_unit_req_i |=> !fwd_a_mu_req_n_o;
  endproperty
  a_mu: assert property (p_mu) else $error("message unit request not forwarded");

  property p_mask;
    @(posedge mclk_i) disable iff (rst_i)
    !nxt_enable[irq_route_pkg::SRC_TIMER0] |-> !irq_pending_set[17] && !fiq_pending_set[17];
  endproperty
  a_mask: assert property (p_mask) else $error("masked source pending");

  property p_disjoint;
    @(posedge mclk_i) disable iff (rst_i)
    (irq_pending_set & fiq_pending_set) == 64'h0;
  endproperty
  a_disjoint: assert property (p_disjoint) else $error("source on both paths");

  property p_irq_out;
    @(posedge mclk_i) disable iff (rst_i)
    (|irq_pending_set) |=> irq_o;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised");

  property p_fiq_off;
    @(posedge mclk_i) disable iff (rst_i)
    !(|fiq_pending_set) |=> !fiq_o;
  endproperty
  a_fiq_off: assert property (p_fiq_off) else $error("fiq raised without pending");

  property p_vec_base;
    @(posedge mclk_i) disable iff (rst_i)
    (irq_pending_set == 64'h1) |=> irq_vector_out_o == $past(handler_base_ff);
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("source 0 vector not base");
endmodule
`default_nettype wire

// File: bench/irq_source_model.sv
// far-side model: external pins, timers, watchdog, peripherals, message unit
// assumes the bench hands it source levels by source index, active high
`timescale 1ns/10ps
`default_nettype none
module irq_source_model #(
  parameter int NUM_PERIPH = 44
) (
  input wire logic mclk_i,
  input wire logic [63:0] level_i,
  input wire logic [7:0] gpio_dir_i,
  input wire logic mu_level_i,
  output logic [7:0] ext_request_pins_n_o,
  output logic [7:0] gpio_request_pins_n_o,
  output logic [7:0] gpio_is_input_o,
  output logic urgent_request_pin_n_o,
  output logic timer0_req_o,
  output logic timer1_req_o,
  output logic wdog_req_o,
  output logic [NUM_PERIPH-1:0] periph_req_o,
  output logic message_unit_req_o
);
  ////////////////////////////////////////////////////////////////////////////
  // gpio pins used as outputs carry a pattern changing every cycle, never a request
  logic [7:0] churn_ff = 8'h5A;
  always @(negedge mclk_i) churn_ff <= ~churn_ff;
  // levels stay until the bench clears the source
  assign ext_request_pins_n_o = ~level_i[7:0];
  assign gpio_request_pins_n_o = (gpio_dir_i & ~level_i[15:8]) | (~gpio_dir_i & churn_ff);
  assign gpio_is_input_o = gpio_dir_i;
  assign urgent_request_pin_n_o = ~level_i[16];
  assign timer0_req_o = level_i[17];
  assign timer1_req_o = level_i[18];
  assign wdog_req_o = level_i[19];
  assign periph_req_o = level_i[20 +: NUM_PERIPH];
  assign message_unit_req_o = mu_level_i;
endmodule
`default_nettype wire

// File: bench/irq_route_prio_vector_unit_tb_top.sv
// self-checking bench for the routing, prioritising and vector unit
// assumes the source model on the far side; coprocessor port driven here
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module irq_route_prio_vector_unit_tb_top;
  typedef struct {logic [3:0] kind; logic [31:0] val;} note_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cp_wr_i = 1'b0;
  logic cp_rd_i = 1'b0;
  logic [3:0] cp_crn_i = 4'h0;
  logic [9:0] cp_bad = 10'h000;
  logic [31:0] cp_wdata_i = 32'h0000_0000;
  logic [63:0] lvl = 64'h0;
  logic [7:0] gdir = 8'h00;
  logic mu_lvl = 1'b0;
  logic rd_d = 1'b0;
  wire logic [7:0] ext_n, gpio_n, gin, fwd_a, fwd_b;
  wire logic urg_n, t0, t1, wd, mu_req, mu_n, irq, fiq;
  wire logic [43:0] per;
  wire logic [31:0] rdata, ivec, fvec;
  note_t notes[$];
  event obs_ev;
  int err_count = 0;
  int num_checks = 0;
  integer seed = 32'h8d921301;

  always #12.5 mclk_i = ~mclk_i;

  irq_source_model src (.mclk_i(mclk_i), .level_i(lvl), .gpio_dir_i(gdir), .mu_level_i(mu_lvl),
    .ext_request_pins_n_o(ext_n), .gpio_request_pins_n_o(gpio_n), .gpio_is_input_o(gin),
    .urgent_request_pin_n_o(urg_n), .timer0_req_o(t0), .timer1_req_o(t1), .wdog_req_o(wd),
    .periph_req_o(per), .message_unit_req_o(mu_req));

  irq_route_prio_vector_unit dut (.mclk_i(mclk_i), .rst_i(rst_i), .ext_request_pins_n_i(ext_n),
    .gpio_request_pins_n_i(gpio_n), .gpio_is_input_i(gin), .urgent_request_pin_n_i(urg_n),
    .timer0_req_i(t0), .timer1_req_i(t1), .wdog_req_i(wd), .periph_req_i(per),
    .message_unit_req_i(mu_req), .cp_wr_i(cp_wr_i), .cp_rd_i(cp_rd_i), .cp_crn_i(cp_crn_i),
    .cp_opcode1_i(cp_bad[9:7]), .cp_opcode2_i(cp_bad[6:4]), .cp_crm_i(cp_bad[3:0]),
    .cp_wdata_i(cp_wdata_i), .cp_rdata_o(rdata), .fwd_a_req_n_o(fwd_a), .fwd_b_req_n_o(fwd_b),
    .fwd_a_mu_req_n_o(mu_n), .irq_o(irq), .fiq_o(fiq), .irq_vector_out_o(ivec),
    .fiq_vector_out_o(fvec));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] observe(input logic [3:0] k);
    case (k)
      4'h1: return {31'h0, irq};
      4'h2: return {31'h0, fiq};
      4'h3: return ivec;
      4'h4: return fvec;
      4'h5: return {24'h0, fwd_a};
      4'h6: return {24'h0, fwd_b};
      4'h7: return {31'h0, mu_n};
      default: return rdata;
    endcase
  endfunction

  task automatic check;
    note_t n;
    n = notes.pop_front();
    `CHK(observe(n.kind), n.val)
  endtask

  // read data is sampled a full cycle after the taking edge, valid either way it lands
  always @(posedge mclk_i)
  begin
    rd_d <= cp_rd_i && (cp_bad == 10'h000) && !rst_i;
    if (rd_d)
    begin
      #1;
      check();
    end
  end

  always @(obs_ev) check();

  ////////////////////////////////////////////////////////////////////////////
  task automatic cp(input logic wr, input logic [3:0] crn, input logic [31:0] d, input logic [9:0] bad);
    @(negedge mclk_i);
    cp_wr_i = wr;
    cp_rd_i = ~wr;
    cp_crn_i = crn;
    cp_wdata_i = d;
    cp_bad = bad;
    @(negedge mclk_i);
    cp_wr_i = 1'b0;
    cp_rd_i = 1'b0;
    cp_bad = 10'h000;
    @(negedge mclk_i);
  endtask

  task automatic wr(input logic [3:0] crn, input logic [31:0] d);
    cp(1'b1, crn, d, 10'h000);
  endtask

  task automatic rd(input logic [3:0] crn, input logic [31:0] e);
    notes.push_back('{4'h0, e});
    cp(1'b0, crn, 32'h0000_0000, 10'h000);
  endtask

  // the delay lets the watcher re-arm before the next probe
  task automatic probe(input logic [3:0] k, input logic [31:0] e);
    notes.push_back('{k, e});
    ->obs_ev;
    #1;
  endtask

  function automatic logic [31:0] vec_of(input logic [63:0] p, input logic [127:0] pr, input logic [31:0] b,
                                         input logic [3:0] sc);
    int best;
    logic [1:0] bp;
    logic [3:0] s;
    best = -1;
    bp = 2'h3;
    for (int i = 0; i < 64; i++)
      if (p[i] && (best < 0 || pr[2*i +: 2] <= bp))
      begin
        best = i;
        bp = pr[2*i +: 2];
      end
    s = (sc < 4'h7) ? 4'h7 : sc;
    return (best < 0) ? b : b + (32'(best) << (s + 1));
  endfunction

  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(25 * 8000);
    err_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r, b;
    logic [63:0] en, st, pi, pf;
    logic [127:0] pr;
    logic [3:0] sc;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    for (int c = 0; c < 16; c++)
      rd(4'(c), 32'h0000_0000);
    probe(4'h1, 32'h0000_0000);
    probe(4'h5, 32'h0000_00ff);
    probe(4'h6, 32'h0000_00ff);
    probe(4'h7, 32'h0000_0001);
    // nonzero opcode or crm fields must leave the register alone
    for (int k = 0; k < 3; k++)
      cp(1'b1, irq_route_pkg::CRN_ENABLE0, 32'hffff_ffff, (k == 0) ? 10'h001 : (k == 1) ? 10'h010 : 10'h080);
    rd(irq_route_pkg::CRN_ENABLE0, 32'h0000_0000);
    wr(irq_route_pkg::CRN_IRQ_PEND0, 32'hffff_ffff);
    rd(irq_route_pkg::CRN_IRQ_PEND0, 32'h0000_0000);
    wr(irq_route_pkg::CRN_ENABLE0, 32'h0001_ffff);
    for (int t = 0; t < 8; t++)
    begin
      @(negedge mclk_i);
      r = $random(seed);
      lvl = {47'h0, 17'($random(seed))};
      gdir = 8'($random(seed));
      mu_lvl = r[31];
      wr(irq_route_pkg::CRN_ROUTE, r);
      rd(irq_route_pkg::CRN_ROUTE, r & irq_route_pkg::ROUTE_MASK);
      repeat (4) @(negedge mclk_i);
      pi = {47'h0, lvl[16], lvl[15:8] & gdir, lvl[7:0] & r[7:0]};
      rd(irq_route_pkg::CRN_IRQ_PEND0, pi[31:0]);
      probe(4'h1, {31'h0, |pi});
      probe(4'h5, {24'h0, ~(lvl[7:0] & ~r[7:0] & ~r[23:16])});
      probe(4'h6, {24'h0, ~(lvl[7:0] & ~r[7:0] & r[23:16])});
      probe(4'h7, {31'h0, ~mu_lvl});
    end
    for (int t = 0; t < 12; t++)
    begin
      @(negedge mclk_i);
      lvl = {$random(seed), $random(seed)} & 64'hffff_ffff_fffe_0000;
      en = {$random(seed), $random(seed)};
      st = {$random(seed), $random(seed)};
      pr = {$random(seed), 32'h0, $random(seed), $random(seed)};
      b = $random(seed);
      sc = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($random(seed));
      wr(irq_route_pkg::CRN_ENABLE0, en[31:0]);
      wr(irq_route_pkg::CRN_ENABLE1, en[63:32]);
      wr(irq_route_pkg::CRN_STEER0, st[31:0]);
      wr(irq_route_pkg::CRN_STEER1, st[63:32]);
      wr(irq_route_pkg::CRN_PRIO0, pr[31:0]);
      wr(4'hA, pr[63:32]);
      wr(irq_route_pkg::CRN_PRIO3, pr[127:96]);
      wr(irq_route_pkg::CRN_BASE, b);
      wr(irq_route_pkg::CRN_SPAN, {28'h0, sc});
      wr(irq_route_pkg::CRN_IRQ_PEND0, ~en[31:0]);
      pi = lvl & en & ~st;
      pf = lvl & en & st;
      rd(irq_route_pkg::CRN_PRIO0, pr[31:0]);
      rd(irq_route_pkg::CRN_IRQ_PEND0, pi[31:0]);
      rd(irq_route_pkg::CRN_IRQ_PEND1, pi[63:32]);
      rd(irq_route_pkg::CRN_FIQ_PEND0, pf[31:0]);
      rd(irq_route_pkg::CRN_FIQ_PEND1, pf[63:32]);
      rd(irq_route_pkg::CRN_IRQ_VEC, vec_of(pi, pr, b, sc));
      rd(irq_route_pkg::CRN_FIQ_VEC, vec_of(pf, pr, b, sc));
      probe(4'h3, vec_of(pi, pr, b, sc));
      probe(4'h4, vec_of(pf, pr, b, sc));
      probe(4'h1, {31'h0, |pi});
      probe(4'h2, {31'h0, |pf});
    end
    // lone source 0 on IRQ: its vector is the base itself
    lvl = 64'h0000_0000_0000_0001;
    wr(irq_route_pkg::CRN_ROUTE, 32'h0000_0001);
    wr(irq_route_pkg::CRN_ENABLE1, 32'h0000_0000);
    wr(irq_route_pkg::CRN_STEER0, 32'h0000_0000);
    wr(irq_route_pkg::CRN_ENABLE0, 32'h0000_0001);
    rd(irq_route_pkg::CRN_IRQ_PEND0, 32'h0000_0001);
    rd(irq_route_pkg::CRN_IRQ_VEC, b);
    probe(4'h1, 32'h0000_0001);
    wr(irq_route_pkg::CRN_ENABLE0, 32'h0000_0000);
    wr(irq_route_pkg::CRN_ENABLE1, 32'h0000_0000);
    probe(4'h1, 32'h0000_0000);
    probe(4'h2, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
